/* core/ebm_pkg.sv */
// Package with register map, field positions and types of the endpoint buffer manager.
package ebm_pkg;
   localparam logic [7:0] EBM_OFF_BUFCS = 8'h00;
   localparam logic [7:0] EBM_OFF_EVT = 8'h04;
   localparam logic [7:0] EBM_OFF_MASK = 8'h08;
   localparam logic [7:0] EBM_OFF_CTRL = 8'h0C;
   localparam logic [7:0] EBM_OFF_LSTAT = 8'h10;
   localparam logic [7:0] EBM_OFF_EPDONE = 8'h14;
   localparam logic [7:0] EBM_OFF_EP2 = 8'h18;
   localparam logic [7:0] EBM_OFF_PWR = 8'h1C;
   localparam int EBM_BIT_CLR = 0;
   localparam int EBM_BIT_STATB = 1;
   localparam int EBM_BIT_CURRENT_BUFFER_INDEX = 3;
   localparam int EBM_BIT_SOF = 0;
   localparam int EBM_BIT_RST = 1;
   localparam int EBM_BIT_SLEEP_EXIT_FLAG = 2;
   localparam int EBM_BIT_IDLE_SLEEP_REQUEST = 3;
   localparam int EBM_BIT_ERR = 4;
   localparam int EBM_BIT_SETUP_OVERRUN_FLAG = 5;
   localparam int EBM_BIT_CTR = 7;
   localparam logic [7:0] EBM_EVT_WMASK = 8'h3F;
   localparam logic [7:0] EBM_RST_VAL = 8'h00;
   localparam int EBM_EP01_HALF = 16;
   localparam int EBM_EP2_HALF = 64;
   localparam int EBM_BLOCK = 512;
   localparam int EBM_NUM_EP = 5;
   localparam int EBM_PKTS = EBM_BLOCK / EBM_EP2_HALF;
   localparam int EBM_CLK_HZ = 20_000_000;
   localparam int EBM_IDLE_SLEEP_REQUEST_MS = 3;
   localparam int EBM_IDLE_SLEEP_REQUEST_CYC = EBM_CLK_HZ / 1000 * EBM_IDLE_SLEEP_REQUEST_MS;
   localparam logic [1:0] EBM_AXI_OKAY = 2'b00;
   localparam logic [1:0] EBM_AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      EBM_MODE_NORMAL = 2'b00,
      EBM_MODE_UPLOAD = 2'b01,
      EBM_MODE_DOWNLOAD = 2'b10,
      EBM_MODE_RSVD = 2'b11
   } ebm_mode_e;

   typedef struct packed {
      logic good;
      logic setup;
      logic ep0;
      logic [1:0] ep;
      logic dir_in;
      logic [1:0] pid;
      logic short_pkt;
      logic err;
      logic [2:0] err_code;
      logic sof;
      logic bus_reset;
      logic idle;
      logic activity;
   } ebm_link_s;
endpackage : ebm_pkg

/* core/ebm_top.sv */
// Endpoint buffering, routing and event logic of the USB function block.
// What this block does
// (R1) Five endpoints; endpoints 1 and 2 give two IN and two OUT endpoints.
// (R2) Endpoints 0 and 1 are 2x16 bytes, endpoint 2 is 2x64 bytes.
// (R3) Two-bit routing select: 00 normal, 10 download, 01 upload.
// (R4) Two 512-byte blocks; coprocessor uses one while USB uses other.
// (R5) Endpoint 2 answers NAK while the current buffer is unavailable at a fresh start.
// (R6) Normal mode: 64 bytes, status goes NAK after good transfer.
// (R7) Upload/download: endpoint 2 address advances 64 bytes per packet.
// (R8) After 512 bytes swap buffers; endpoint invalid while the new one is not free.
// (R9) A short packet reverts to normal mode, data stays in big buffer.
// (R10) Bit 3 shows which big buffer holds endpoint 2 data.
// (R11) Bits 2:1 show the fill state of each big buffer.
// (R12) Writing 1 to clear bit reinitialises manager; 0 does nothing.
// (R13) Control register bits 7:4 read zero; only bit 0 writable.
// (R14) In wait mode USB runs on and enabled events wake the core.
// (R15) In halt USB logic is idle; resumes on wake or bus activity.
// (R16) End of suspend has its own vector; other events share one.
// (R17) Interrupt request only when event flag and its enable are set.
// (R18) Only hardware sets event flags; software reads and clears them.
// (R19) Good transfer bit is OR of endpoint done flags.
// (R20) NAK or STALL answered or erroneous transactions are not correct.
// (R21) Setup overrun sets on SETUP while endpoint 0 done; no status update.
// (R22) Error flag sets on timeout, CRC, stuffing, framing or overrun.
// (R23) Suspend request sets after more than 3 ms continuous idle.
// (R24) Error code loads on error and clears when the error flag clears.
// (R25) Software clears flags by writing 0 to them and 1 elsewhere.
module ebm_top
   import ebm_pkg::*;
#(
   parameter int IDLE_SLEEP_REQUEST_CYCLES = EBM_IDLE_SLEEP_REQUEST_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire ebm_pkg::ebm_link_s LINK,
   input wire logic [1:0] COPROC_RELEASE,
   input wire logic HALT_MODE,
   output logic [1:0] EP2_STATUS,
   output logic EP2_BUF_SEL,
   output logic [8:0] EP2_ADDR,
   output logic USB_IRQ,
   output logic WAKE_IRQ
);
   import ebm_pkg::*;

   // Endpoint 2 status codes driven to the transaction engine.
   localparam logic [1:0] EP_DISABLED = 2'b00;
   localparam logic [1:0] EP_NAK = 2'b10;
   localparam logic [1:0] EP_VALID = 2'b11;

   logic aw_ok, w_ok, wr_go, rd_go;
   logic [7:0] aw_ff, ar_ff, wr_addr;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;
   logic aw_have_ff, w_have_ff;
   logic [7:0] evt_ff, mask_ff, lstat_ff;
   logic [2:0] ep_done_ff;
   logic [1:0] route_ff, ep2_stat_ff;
   logic current_buffer_index_ff;
   logic swap_ff;
   logic [1:0] statb_ff;
   logic [2:0] pkt_ff;
   logic [31:0] idle_cnt_ff;
   logic active;
   logic clr_wr, evt_wr, done_wr, ep2_wr;
   logic [7:0] wbyte;
   logic good_ep2;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   // Write channel: address and data taken in either order.
   assign S_AXI_AWREADY = !aw_have_ff && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_have_ff && !S_AXI_BVALID;
   assign aw_ok = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_ok = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_go = (aw_have_ff || aw_ok) && (w_have_ff || w_ok);
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_ff <= EBM_RST_VAL;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= EBM_AXI_OKAY;
      end else begin
         if (aw_ok) aw_ff <= S_AXI_AWADDR;
         if (w_ok) begin
            wd_ff <= S_AXI_WDATA;
            ws_ff <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (wr_addr > EBM_OFF_PWR || wr_addr[1:0] != 2'b00)
                           ? EBM_AXI_SLVERR : EBM_AXI_OKAY;
         end else begin
            if (aw_ok) aw_have_ff <= 1'b1;
            if (w_ok) w_have_ff <= 1'b1;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
      end
   end

   // Address of the write being completed, held or still on the bus.
   // Kept as a net so that every decode below follows it without delay.
   assign wr_addr = aw_have_ff ? aw_ff : S_AXI_AWADDR;

   // Only lane 0 carries register bits; a write without it stores nothing.
   assign wbyte = w_have_ff ? wd_ff[7:0] : S_AXI_WDATA[7:0];
   wire lane0 = w_have_ff ? ws_ff[0] : S_AXI_WSTRB[0];
   assign clr_wr = wr_go && lane0 && hit(wr_addr, EBM_OFF_BUFCS)
                   && wbyte[EBM_BIT_CLR]; // R12
   assign evt_wr = wr_go && lane0 && hit(wr_addr, EBM_OFF_EVT);
   assign done_wr = wr_go && lane0 && hit(wr_addr, EBM_OFF_EPDONE);
   assign ep2_wr = wr_go && lane0 && hit(wr_addr, EBM_OFF_EP2);

   // Halt stops the USB logic except for wake detection.
   assign active = !HALT_MODE; // R15

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         mask_ff <= EBM_RST_VAL;
         route_ff <= EBM_MODE_NORMAL;
      end else begin
         if (wr_go && lane0 && hit(wr_addr, EBM_OFF_MASK))
            mask_ff <= wbyte & ~8'h40;
         if (wr_go && lane0 && hit(wr_addr, EBM_OFF_CTRL))
            route_ff <= wbyte[1:0]; // R3
         else if (active && good_ep2 && LINK.short_pkt &&
                  route_ff != EBM_MODE_NORMAL)
            route_ff <= EBM_MODE_NORMAL; // R9
      end
   end

   // Correct transfers only; the link engine never flags NAK/STALL as good.
   assign good_ep2 = LINK.good && !LINK.err && LINK.ep == 2'd2; // R20

   // Endpoint done flags: hardware set wins over software clear.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ep_done_ff <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (active && LINK.good && !LINK.err && LINK.ep == 2'(i)
                && !(i == 0 && LINK.setup && ep_done_ff[0]))
               ep_done_ff[i] <= 1'b1; // R20
            else if (done_wr && !wbyte[i])
               ep_done_ff[i] <= 1'b0; // R25
         end
      end
   end

   // Idle counter for the suspend request.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) idle_cnt_ff <= 32'h0000_0000;
      else if (!LINK.idle || LINK.bus_reset) idle_cnt_ff <= 32'h0000_0000;
      else if (idle_cnt_ff <= 32'(IDLE_SLEEP_REQUEST_CYCLES)) idle_cnt_ff <= idle_cnt_ff + 1;
   end

   wire idle_sleep_request_hit = idle_cnt_ff == 32'(IDLE_SLEEP_REQUEST_CYCLES); // R23

   // Event flags: set wins, write of 0 clears, 1 leaves alone.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         evt_ff <= EBM_RST_VAL;
      end else begin
         for (int i = 0; i < 6; i++) begin
            logic set;
            set = 1'b0;
            case (i)
               EBM_BIT_SOF: set = active && LINK.sof;
               EBM_BIT_RST: set = active && LINK.bus_reset;
               EBM_BIT_SLEEP_EXIT_FLAG: set = HALT_MODE && LINK.activity; // R15
               EBM_BIT_IDLE_SLEEP_REQUEST: set = active && idle_sleep_request_hit; // R23
               EBM_BIT_ERR: set = active && LINK.err; // R22
               EBM_BIT_SETUP_OVERRUN_FLAG: set = active && LINK.good && !LINK.err &&
                                   LINK.setup && ep_done_ff[0]; // R21
               default: set = 1'b0;
            endcase
            if (set) evt_ff[i] <= 1'b1; // R18
            else if (evt_wr && !wbyte[i]) evt_ff[i] <= 1'b0;
         end
      end
   end

   // Link status: not updated on a setup overrun; error code follows flag.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         lstat_ff <= EBM_RST_VAL;
      end else begin
         if (active && LINK.err)
            lstat_ff[2:0] <= LINK.err_code; // R24
         else if (evt_wr && !wbyte[EBM_BIT_ERR])
            lstat_ff[2:0] <= 3'b000; // R24
         if (active && LINK.good && !LINK.err &&
             !(LINK.setup && ep_done_ff[0])) begin // R21
            lstat_ff[7:6] <= LINK.pid;
            lstat_ff[5] <= LINK.dir_in;
            lstat_ff[4:3] <= LINK.ep;
         end
      end
   end

   // Buffer manager: packet counter, current buffer and fill states.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pkt_ff <= 3'd0;
         current_buffer_index_ff <= 1'b0;
         statb_ff <= 2'b00;
         swap_ff <= 1'b0;
      end else if (clr_wr) begin
         pkt_ff <= 3'd0; // R12
         current_buffer_index_ff <= 1'b0;
         statb_ff <= 2'b00;
         swap_ff <= 1'b0;
      end else begin
         for (int b = 0; b < 2; b++)
            if (COPROC_RELEASE[b]) statb_ff[b] <= // R4
               (route_ff == EBM_MODE_UPLOAD); // R11
         if (active && good_ep2 && route_ff != EBM_MODE_NORMAL) begin
            if (LINK.short_pkt || pkt_ff == 3'(EBM_PKTS - 1)) begin
               pkt_ff <= 3'd0; // R7
               statb_ff[current_buffer_index_ff] <= route_ff == EBM_MODE_DOWNLOAD; // R11
               if (!LINK.short_pkt) current_buffer_index_ff <= !current_buffer_index_ff; // R8
               swap_ff <= !LINK.short_pkt; // R8
            end else begin
               pkt_ff <= pkt_ff + 3'd1; // R7
            end
         end
      end
   end

   // Is the current buffer usable by the USB side in this direction.
   wire buf_ready = (route_ff == EBM_MODE_UPLOAD) ? statb_ff[current_buffer_index_ff]
                                                 : !statb_ff[current_buffer_index_ff];

   // Endpoint 2 handshake status.
   // A fresh start only NAKs; a full block that lands on an unready buffer
   // leaves the endpoint invalid until the coprocessor hands one back.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ep2_stat_ff <= EP_NAK;
      end else if (ep2_wr) begin
         ep2_stat_ff <= wbyte[1:0];
      end else if (route_ff == EBM_MODE_NORMAL) begin
         if (active && good_ep2) ep2_stat_ff <= EP_NAK; // R6
      end else if (pkt_ff == 3'd0 && !buf_ready) begin
         ep2_stat_ff <= swap_ff ? EP_DISABLED : EP_NAK; // R5 R8
      end else begin
         ep2_stat_ff <= EP_VALID;
      end
   end

   // Endpoint sizes are fixed by the RAM map; only endpoint 2 moves.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         EP2_ADDR <= 9'd0;
         EP2_BUF_SEL <= 1'b0;
         EP2_STATUS <= EP_NAK;
      end else begin
         EP2_ADDR <= (route_ff == EBM_MODE_NORMAL) ? 9'd0
                     : 9'(pkt_ff * EBM_EP2_HALF); // R2 R7
         EP2_BUF_SEL <= current_buffer_index_ff; // R10
         EP2_STATUS <= ep2_stat_ff;
      end
   end

   // Read side; reserved bits read zero.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= EBM_AXI_OKAY;
         ar_ff <= EBM_RST_VAL;
      end else if (rd_go) begin
         S_AXI_RVALID <= 1'b1;
         ar_ff <= S_AXI_ARADDR;
         S_AXI_RRESP <= EBM_AXI_OKAY;
         case (S_AXI_ARADDR)
            EBM_OFF_BUFCS: S_AXI_RDATA <= {28'h0, current_buffer_index_ff,
                                           statb_ff, 1'b0}; // R13
            EBM_OFF_EVT: S_AXI_RDATA <= {24'h0, |ep_done_ff,
                                         1'b0, evt_ff[5:0]}; // R19
            EBM_OFF_MASK: S_AXI_RDATA <= {24'h0, mask_ff};
            EBM_OFF_CTRL: S_AXI_RDATA <= {30'h0, route_ff};
            EBM_OFF_LSTAT: S_AXI_RDATA <= {24'h0, lstat_ff};
            EBM_OFF_EPDONE: S_AXI_RDATA <= {29'h0, ep_done_ff};
            EBM_OFF_EP2: S_AXI_RDATA <= {30'h0, ep2_stat_ff};
            EBM_OFF_PWR: S_AXI_RDATA <= {31'h0, HALT_MODE};
            default: begin
               S_AXI_RDATA <= 32'h0000_0000;
               S_AXI_RRESP <= EBM_AXI_SLVERR;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // Interrupt lines; neither wait nor halt is gated here, in halt only the wake flag can newly set.
   wire [7:0] flags = {|ep_done_ff, 1'b0, evt_ff[5:0]};
   wire [7:0] pend = flags & mask_ff; // R17
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         USB_IRQ <= 1'b0;
         WAKE_IRQ <= 1'b0;
      end else begin
         USB_IRQ <= |(pend & ~(8'h01 << EBM_BIT_SLEEP_EXIT_FLAG)); // R14 R16
         WAKE_IRQ <= pend[EBM_BIT_SLEEP_EXIT_FLAG]; // R16
      end
   end

   // Three endpoint done flags cover five endpoints, ep1/ep2 carry both ways.
   localparam int EP_SLOTS = 3; // R1

   AST_CLR_RESET: assert property (@(posedge REF_CLK) disable iff (RST)
      clr_wr |=> statb_ff == 2'b00 && !current_buffer_index_ff && pkt_ff == 3'd0) // R12
      else $error("clear did not reset buffer manager");
   AST_IRQ_GATE: assert property (@(posedge REF_CLK) disable iff (RST)
      USB_IRQ |-> $past(|(flags & mask_ff))) // R17
      else $error("interrupt without enabled flag");
   AST_WAKE: assert property (@(posedge REF_CLK) disable iff (RST)
      WAKE_IRQ |-> $past(evt_ff[EBM_BIT_SLEEP_EXIT_FLAG] && mask_ff[EBM_BIT_SLEEP_EXIT_FLAG]))
      else $error("wake vector without end of suspend"); // R16
   AST_CTR_OR: assert property (@(posedge REF_CLK) disable iff (RST)
      rd_go && S_AXI_ARADDR == EBM_OFF_EVT |=>
      S_AXI_RDATA[EBM_BIT_CTR] == $past(|ep_done_ff)) // R19
      else $error("good transfer bit not OR of endpoint flags");
   AST_SETUP_OVERRUN_FLAG: assert property (@(posedge REF_CLK) disable iff (RST)
      active && LINK.good && !LINK.err && LINK.setup && ep_done_ff[0]
      |=> evt_ff[EBM_BIT_SETUP_OVERRUN_FLAG] && $stable(lstat_ff[7:3])) // R21
      else $error("setup overrun handled wrongly");
   AST_ERR: assert property (@(posedge REF_CLK) disable iff (RST)
      active && LINK.err |=> evt_ff[EBM_BIT_ERR] &&
      lstat_ff[2:0] == $past(LINK.err_code)) // R22
      else $error("error flag or code not loaded");
   AST_NAK_NORMAL: assert property (@(posedge REF_CLK) disable iff (RST)
      route_ff == EBM_MODE_NORMAL && active && good_ep2 && !ep2_wr
      |=> ep2_stat_ff == EP_NAK) // R6
      else $error("endpoint 2 not NAK after normal transfer");
   AST_SHORT: assert property (@(posedge REF_CLK) disable iff (RST)
      active && good_ep2 && LINK.short_pkt && !(wr_go &&
      hit(wr_addr, EBM_OFF_CTRL)) |=> route_ff == EBM_MODE_NORMAL) // R9
      else $error("short packet did not revert to normal mode");
   AST_RSVD: assert property (@(posedge REF_CLK) disable iff (RST)
      S_AXI_RVALID && ar_ff == EBM_OFF_BUFCS |->
      S_AXI_RDATA[7:4] == 4'h0) // R13
      else $error("reserved bits not zero");
   AST_SWAP: assert property (@(posedge REF_CLK) disable iff (RST)
      active && good_ep2 && !LINK.short_pkt && !clr_wr &&
      route_ff == EBM_MODE_UPLOAD && pkt_ff == 3'(EBM_PKTS - 1)
      |=> current_buffer_index_ff != $past(current_buffer_index_ff)) // R8
      else $error("buffer did not switch after a full block");
   AST_FRESH_NAK: assert property (@(posedge REF_CLK) disable iff (RST)
      route_ff == EBM_MODE_UPLOAD && !swap_ff && pkt_ff == 3'd0 &&
      !statb_ff[current_buffer_index_ff] && !ep2_wr |=> ep2_stat_ff == EP_NAK) // R5
      else $error("endpoint 2 not NAK while its buffer is not ready");
endmodule : ebm_top

/* bench/ebm_link_model.sv */
// Model of the transaction engine and transfer coprocessor at the far side.
module ebm_link_model
   import ebm_pkg::*;
(
   input wire logic clk,
   output ebm_pkg::ebm_link_s link,
   output logic [1:0] release_buf
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      link = '0;
      release_buf = 2'b00;
   end

   // The idle level belongs to the bus, so a pulse never disturbs it.
   // Between pulses the error code shows its inverse, never a stale value.
   task automatic pulse(input ebm_link_s ev);
      ebm_link_s quiet;
      quiet = '0;
      quiet.idle = link.idle;
      quiet.err_code = ~ev.err_code;
      ev.idle = link.idle;
      @(posedge clk);
      link <= ev;
      @(posedge clk);
      link <= quiet;
   endtask : pulse

   task automatic set_idle(input logic lvl);
      @(posedge clk);
      link.idle <= lvl;
   endtask : set_idle

   // The coprocessor hands a block back only when it is done with it.
   task automatic release_block(input int n);
      @(posedge clk);
      release_buf[n] <= 1'b1;
      @(posedge clk);
      release_buf <= 2'b00;
   endtask : release_block
endmodule : ebm_link_model

/* bench/test_usb_endpoint_buffer_manager.sv */
// Self-checking testbench of the endpoint buffer manager.
module test_usb_endpoint_buffer_manager
   import ebm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IDLE_SLEEP_REQUEST = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] aw_addr = 8'h00;
   logic aw_valid = 1'b0;
   logic [31:0] w_data = 32'h0000_0000;
   logic w_valid = 1'b0;
   logic b_ready = 1'b0;
   logic [7:0] ar_addr = 8'h00;
   logic ar_valid = 1'b0;
   logic r_ready = 1'b0;
   logic halt = 1'b0;
   logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, usb_irq, wake_irq, buf_sel;
   logic [1:0] b_resp, r_resp, ep2_st, rel, resp;
   logic [31:0] r_data;
   logic [8:0] ep2_addr;
   ebm_link_s link;
   int bad_count = 0;
   int cmp_count = 0;

   always #25 clk = ~clk;

   ebm_link_model far (.clk(clk), .link(link), .release_buf(rel));

   ebm_top #(.IDLE_SLEEP_REQUEST_CYCLES(IDLE_SLEEP_REQUEST)) uut (
      .REF_CLK(clk),
      .RST(rst),
      .S_AXI_AWADDR(aw_addr),
      .S_AXI_AWVALID(aw_valid),
      .S_AXI_AWREADY(aw_rdy),
      .S_AXI_WDATA(w_data),
      .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(w_valid),
      .S_AXI_WREADY(w_rdy),
      .S_AXI_BRESP(b_resp),
      .S_AXI_BVALID(b_valid),
      .S_AXI_BREADY(b_ready),
      .S_AXI_ARADDR(ar_addr),
      .S_AXI_ARVALID(ar_valid),
      .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(r_data),
      .S_AXI_RRESP(r_resp),
      .S_AXI_RVALID(r_valid),
      .S_AXI_RREADY(r_ready),
      .LINK(link),
      .COPROC_RELEASE(rel),
      .HALT_MODE(halt),
      .EP2_STATUS(ep2_st),
      .EP2_BUF_SEL(buf_sel),
      .EP2_ADDR(ep2_addr),
      .USB_IRQ(usb_irq),
      .WAKE_IRQ(wake_irq)
   );

   task automatic check(input string what, input logic [8:0] seen,
      input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge clk);
      aw_addr <= a;
      w_data <= {24'h00_0000, d};
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk);
         if (aw_p && aw_rdy) begin
            aw_p = 1'b0;
            aw_valid <= 1'b0;
         end
         if (w_p && w_rdy) begin
            w_p = 1'b0;
            w_valid <= 1'b0;
         end
      end
      do @(posedge clk); while (b_valid !== 1'b1);
      resp = b_resp;
      b_ready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge clk);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do @(posedge clk); while (ar_rdy !== 1'b1);
      ar_valid <= 1'b0;
      do @(posedge clk); while (r_valid !== 1'b1);
      resp = r_resp;
      r_ready <= 1'b0;
      check($sformatf("reg %h", a), 9'(r_data[7:0] & m), 9'(e));
   endtask : rd

   task automatic complete_run;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // The whole sequence needs well under 2000 cycles; this allows five times.
   initial begin
      #500_000;
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      check("ep2 status", 9'(ep2_st), 9'h002);
      rd(EBM_OFF_BUFCS, 8'hFF, 8'h00);
      wr(EBM_OFF_BUFCS, 8'hFE);
      check("write resp", 9'(resp), 9'(EBM_AXI_OKAY));
      rd(EBM_OFF_BUFCS, 8'hFF, 8'h00);
      wr(EBM_OFF_EVT, 8'hFF);
      rd(EBM_OFF_EVT, 8'hFF, 8'h00);
      wr(8'h20, 8'h01);
      check("unmapped resp", 9'(resp), 9'(EBM_AXI_SLVERR));
      rd(8'h20, 8'hFF, 8'h00);
      check("unmapped rresp", 9'(resp), 9'(EBM_AXI_SLVERR));
      $display("test registers done");
      far.pulse(ebm_link_s'{sof: 1'b1, default: '0});
      rd(EBM_OFF_EVT, 8'hFF, 8'h01);
      check("usb irq", 9'(usb_irq), 9'h000);
      wr(EBM_OFF_MASK, 8'h01);
      tick(2);
      check("usb irq", 9'(usb_irq), 9'h001);
      check("wake irq", 9'(wake_irq), 9'h000);
      wr(EBM_OFF_EVT, 8'hFE);
      rd(EBM_OFF_EVT, 8'hFF, 8'h00);
      check("usb irq", 9'(usb_irq), 9'h000);
      far.pulse(ebm_link_s'{err: 1'b1, err_code: 3'b101, ep: 2'd2, default: '0});
      far.pulse(ebm_link_s'{bus_reset: 1'b1, default: '0});
      rd(EBM_OFF_EVT, 8'hFF, 8'h12);
      rd(EBM_OFF_LSTAT, 8'h07, 8'h05);
      rd(EBM_OFF_EPDONE, 8'hFF, 8'h00);
      wr(EBM_OFF_EVT, 8'hEF);
      rd(EBM_OFF_LSTAT, 8'h07, 8'h00);
      rd(EBM_OFF_EVT, 8'hFF, 8'h02);
      wr(EBM_OFF_EVT, 8'hC0);
      $display("test events done");
      wr(EBM_OFF_MASK, 8'h05);
      halt <= 1'b1;
      far.pulse(ebm_link_s'{sof: 1'b1, default: '0});
      rd(EBM_OFF_EVT, 8'hFF, 8'h00);
      far.pulse(ebm_link_s'{activity: 1'b1, default: '0});
      tick(2);
      check("wake irq", 9'(wake_irq), 9'h001);
      check("usb irq", 9'(usb_irq), 9'h000);
      rd(EBM_OFF_EVT, 8'hFF, 8'h04);
      halt <= 1'b0;
      wr(EBM_OFF_EVT, 8'hC0);
      wr(EBM_OFF_MASK, 8'h00);
      $display("test wake done");
      wr(EBM_OFF_EP2, 8'h03);
      tick(2);
      check("ep2 status", 9'(ep2_st), 9'h003);
      far.pulse(ebm_link_s'{good: 1'b1, ep: 2'd2, default: '0});
      tick(2);
      check("ep2 status", 9'(ep2_st), 9'h002);
      rd(EBM_OFF_LSTAT, 8'h38, 8'h10);
      wr(EBM_OFF_EVT, 8'h7F);
      rd(EBM_OFF_EVT, 8'hFF, 8'h80);
      wr(EBM_OFF_EPDONE, 8'h00);
      rd(EBM_OFF_EVT, 8'hFF, 8'h00);
      far.pulse(ebm_link_s'{good: 1'b1, default: '0});
      far.pulse(ebm_link_s'{good: 1'b1, setup: 1'b1, pid: 2'b11, default: '0});
      rd(EBM_OFF_EVT, 8'hFF, 8'hA0);
      rd(EBM_OFF_LSTAT, 8'hC0, 8'h00);
      rd(EBM_OFF_EPDONE, 8'hFF, 8'h01);
      wr(EBM_OFF_EPDONE, 8'h00);
      wr(EBM_OFF_EVT, 8'hC0);
      $display("test transfers done");
      far.set_idle(1'b1);
      tick(IDLE_SLEEP_REQUEST - 15);
      rd(EBM_OFF_EVT, 8'h08, 8'h00);
      tick(20);
      rd(EBM_OFF_EVT, 8'h08, 8'h08);
      far.set_idle(1'b0);
      wr(EBM_OFF_EVT, 8'hC0);
      $display("test suspend done");
      wr(EBM_OFF_CTRL, 8'h01);
      tick(2);
      check("ep2 status", 9'(ep2_st), 9'h002);
      far.release_block(0);
      tick(2);
      rd(EBM_OFF_BUFCS, 8'hFF, 8'h02);
      check("ep2 status", 9'(ep2_st), 9'h003);
      for (int k = 1; k <= EBM_PKTS; k++) begin
         far.pulse(ebm_link_s'{good: 1'b1, ep: 2'd2, dir_in: 1'b1, default: '0});
         tick(2);
         check("ep2 addr", ep2_addr,
               9'((k % EBM_PKTS) * EBM_EP2_HALF));
      end
      tick(1);
      check("ep2 status", 9'(ep2_st), 9'h000);
      far.release_block(1);
      tick(3);
      check("ep2 status", 9'(ep2_st), 9'h003);
      check("ep2 buffer", 9'(buf_sel), 9'h001);
      wr(EBM_OFF_BUFCS, 8'h01);
      rd(EBM_OFF_BUFCS, 8'hFF, 8'h00);
      check("ep2 buffer", 9'(buf_sel), 9'h000);
      check("ep2 addr", ep2_addr, 9'h000);
      $display("test upload done");
      wr(EBM_OFF_CTRL, 8'h02);
      far.pulse(ebm_link_s'{good: 1'b1, ep: 2'd2, default: '0});
      tick(2);
      check("ep2 addr", ep2_addr, 9'h040);
      far.pulse(ebm_link_s'{good: 1'b1, ep: 2'd2, short_pkt: 1'b1, default: '0});
      rd(EBM_OFF_CTRL, 8'h03, 8'h00);
      rd(EBM_OFF_BUFCS, 8'h0E, 8'h02);
      $display("test download done");
      complete_run();
   end
endmodule : test_usb_endpoint_buffer_manager
